// [verilog/crc_clock_reset.sv]
/*
  Core clock select, divide and gate control, power-down wake clock
  handling and system reset combination, with its special function
  registers. Oscillator taps arrive as one-cycle ticks on ref_clk;
  reset sources and the crystal-ready level arrive from other domains.
*/
`timescale 1ns/1ns
`include "crc_params.svh"

// Notes on behaviour
// R1: Eight-meg divider field bits 7:5 divides 8 MHz tap by 1..16384.
// R2: Sixteen-meg divider field bits 2:0 divides 16 MHz source by 1..16384.
// R3: RC select bit 4 set picks fast RC oscillator; else tap select decides.
// R4: Tap select bit 3 picks 16 MHz crystal tap, else 8 MHz tap.
// R5: After reset the core runs undivided from the 8 MHz crystal tap once the crystal is stable.
// R6: Status bit 7 shows a core clock change in progress, read-only.
// R7: Entering power-down sets RC wake status; wake-up runs from RC oscillator.
// R8: Software clears RC wake status by writing; normal source then returns.
// R9: Bits 5:0 of the wake status register read as zero.
// R10: Core runs from RC until the crystal is stable.
// R11: Gate zero enables SPI, UARTs, GPIO, timers; bits 6..4 reset to one.
// R12: Gate one enables I2C, IR, flash, voice, audio, quadrature, random.
// R13: Gate two enables PWM 4..0, radio, 3 V logic, controller; low three reset one.
// R14: Gate three: port interrupt gates on bits 3..1, watchdog bit 0 resets one.
// R15: System reset on power-on, brown-out, watchdog or pin low over 62.5 us.
// R16: Any system reset zeroes program counter and restores the select, gate, power-down and wake status registers.
// R17: Radio MAC/PHY reset also follows a software command.
// R18: Power-down bit set by writing one; cleared by wake interrupt or reset.
// R19: Clock switches happen on a period boundary; status holds until done.
module crc_clock_reset #(
  parameter int EXT_RST_CYCLES = int'($ceil(`CRC_EXT_RST_US * `CRC_CLK_MHZ))
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Special function register port
  input  wire logic [7:0]  sfrAddr,
  input  wire logic        sfrWrite,
  input  wire logic        sfrRead,
  input  wire logic [7:0]  sfrWdata,
  output logic      [7:0]  sfrRdata,
  // Oscillator ticks and status
  input  wire logic        xtal8Tick,
  input  wire logic        xtal16Tick,
  input  wire logic        rcTick,
  input  wire logic        xtalStable,
  // Reset sources and wake
  input  wire logic        external_reset_pin_n,
  input  wire logic        powerOnReset,
  input  wire logic        brownout_reset,
  input  wire logic        watchdogTimeout,
  input  wire logic        wakeIrq,
  input  wire logic        macPhySoftReset,
  // Core clock and power
  output logic             coreClkTick,
  output logic             clkChanging,
  output logic             power_down_request,
  // Resets
  output logic             sysReset,
  output logic             macPhyReset,
  output logic      [15:0] resetVector,
  // Peripheral clock gates
  output logic      [7:0]  periph_clock_gate_zero,
  output logic      [7:0]  periph_clock_gate_one,
  output logic      [7:0]  periph_clock_gate_two,
  output logic      [7:0]  periph_clock_gate_three
);

  logic [7:0]          core_clock_select_divide;
  logic                rc_wake_status;
  logic [4:0]          syncA;
  logic [4:0]          syncB;
  logic [15:0]         extLowCnt;
  logic                extLong;
  logic [13:0]         divCnt;
  logic [13:0]         actLim;
  logic                srcTick;
  crc_pkg::crc_src_t   reqSrc;
  crc_pkg::crc_src_t   actSrc;
  logic [2:0]          reqCode;
  logic [2:0]          actCode;
  crc_pkg::crc_state_t state;
  logic                wrSel;
  logic                wrWake;
  logic                wrPwr;
  logic                xtalOk;
  logic                extLow;
  logic                anyRst;

  function automatic logic [13:0] ratioLim(input logic [2:0] code);
    case (code)
      3'h0:    ratioLim = `CRC_LIM0;
      3'h1:    ratioLim = `CRC_LIM1;
      3'h2:    ratioLim = `CRC_LIM2;
      3'h3:    ratioLim = `CRC_LIM3;
      3'h4:    ratioLim = `CRC_LIM4;
      3'h5:    ratioLim = `CRC_LIM5;
      3'h6:    ratioLim = `CRC_LIM6;
      default: ratioLim = `CRC_LIM7;
    endcase
  endfunction

  // Pins and analogue flags come from other domains
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= `CRC_SYNC_RST;
      syncB <= `CRC_SYNC_RST;
    end else begin
      syncA <= {external_reset_pin_n, powerOnReset, brownout_reset, watchdogTimeout,
                xtalStable};
      syncB <= syncA;
    end
  end

  assign xtalOk = syncB[0];
  assign extLow = !syncB[4];

  // A short glitch on the pin never resets; only a sustained low does
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      extLowCnt <= 16'h0000;
    end else if (!extLow) begin
      extLowCnt <= 16'h0000;
    end else if (!extLong) begin
      extLowCnt <= extLowCnt + 16'h0001; // [R15]
    end
  end

  assign extLong = (extLowCnt >= 16'(EXT_RST_CYCLES));
  assign anyRst  = extLong || syncB[3] || syncB[2] || syncB[1]; // [R15]

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sysReset    <= 1'b1;
      macPhyReset <= 1'b1;
      resetVector <= `CRC_PC_RESET;
    end else begin
      sysReset    <= anyRst;
      macPhyReset <= anyRst || macPhySoftReset; // [R17]
      resetVector <= `CRC_PC_RESET;             // [R16]
    end
  end

  assign wrSel  = sfrWrite && (sfrAddr == `CRC_ADDR_SELDIV);
  assign wrWake = sfrWrite && (sfrAddr == `CRC_ADDR_WAKE);
  assign wrPwr  = sfrWrite && (sfrAddr == `CRC_ADDR_PWRCTL);

  // Every register returns to its reset value on any system reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_clock_select_divide <= `CRC_SELDIV_RST; // [R5]
      periph_clock_gate_zero   <= `CRC_GATE0_RST;  // [R11]
      periph_clock_gate_one    <= `CRC_GATE1_RST;  // [R12]
      periph_clock_gate_two    <= `CRC_GATE2_RST;  // [R13]
      periph_clock_gate_three  <= `CRC_GATE3_RST;  // [R14]
    end else if (sysReset) begin
      core_clock_select_divide <= `CRC_SELDIV_RST; // [R16]
      periph_clock_gate_zero   <= `CRC_GATE0_RST;
      periph_clock_gate_one    <= `CRC_GATE1_RST;
      periph_clock_gate_two    <= `CRC_GATE2_RST;
      periph_clock_gate_three  <= `CRC_GATE3_RST;
    end else if (sfrWrite) begin
      case (sfrAddr)
        `CRC_ADDR_SELDIV: core_clock_select_divide <= sfrWdata;
        `CRC_ADDR_GATE0:  periph_clock_gate_zero   <= sfrWdata;          // [R11]
        `CRC_ADDR_GATE1:  periph_clock_gate_one    <= sfrWdata;          // [R12]
        `CRC_ADDR_GATE2:  periph_clock_gate_two    <= sfrWdata;          // [R13]
        `CRC_ADDR_GATE3:  periph_clock_gate_three  <= sfrWdata & `CRC_GATE3_MASK; // [R14]
        default: ;
      endcase
    end
  end

  // Software write wins over a wake in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_down_request <= 1'b0;
    end else if (sysReset) begin
      power_down_request <= 1'b0;                          // [R18]
    end else if (wrPwr && sfrWdata[`CRC_PD_BIT]) begin
      power_down_request <= 1'b1;                          // [R18]
    end else if (wakeIrq) begin
      power_down_request <= 1'b0;                          // [R18]
    end
  end

  // Entry to power-down beats a clearing write in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rc_wake_status <= 1'b0;
    end else if (sysReset) begin
      rc_wake_status <= 1'b0;
    end else if (wrPwr && sfrWdata[`CRC_PD_BIT] && !power_down_request) begin
      rc_wake_status <= 1'b1;                              // [R7]
    end else if (wrWake && !sfrWdata[`CRC_RCWAKE_BIT]) begin
      rc_wake_status <= 1'b0;                              // [R8]
    end
  end

  // Requested source and division
  always_comb begin
    if (rc_wake_status || !xtalOk || core_clock_select_divide[`CRC_RCSEL_BIT]) begin
      reqSrc = crc_pkg::SRC_RC;                            // [R3] [R7] [R10]
    end else if (core_clock_select_divide[`CRC_X16SEL_BIT]) begin
      reqSrc = crc_pkg::SRC_X16;                           // [R4]
    end else begin
      reqSrc = crc_pkg::SRC_X8;                            // [R4] [R5]
    end
    if (reqSrc == crc_pkg::SRC_X8) begin
      reqCode = core_clock_select_divide[`CRC_DIV8_HI:`CRC_DIV8_LO];   // [R1]
    end else begin
      reqCode = core_clock_select_divide[`CRC_DIV16_HI:`CRC_DIV16_LO]; // [R2]
    end
  end

  always_comb begin
    case (actSrc)
      crc_pkg::SRC_X8:  srcTick = xtal8Tick;
      crc_pkg::SRC_X16: srcTick = xtal16Tick;
      default:          srcTick = rcTick;
    endcase
  end

  assign actLim = ratioLim(actCode);

  // Divider counts ticks of the active source
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt      <= 14'h0000;
      coreClkTick <= 1'b0;
    end else if (srcTick && divCnt >= actLim) begin
      divCnt      <= 14'h0000;                             // [R1] [R2]
      coreClkTick <= 1'b1;
    end else begin
      divCnt      <= srcTick ? divCnt + 14'h0001 : divCnt;
      coreClkTick <= 1'b0;
    end
  end

  // New setting is taken only at a period boundary, so no runt period.
  // A stopped old source stalls the switch until it ticks again and completes its current period.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state       <= crc_pkg::CK_RUN;
      actSrc      <= crc_pkg::SRC_X8;                      // [R5]
      actCode     <= 3'h0;
      clkChanging <= 1'b0;
    end else begin
      case (state)
        crc_pkg::CK_RUN: begin
          if (reqSrc != actSrc || reqCode != actCode) begin
            state       <= crc_pkg::CK_SWITCH;             // [R6]
            clkChanging <= 1'b1;
          end
        end
        crc_pkg::CK_SWITCH: begin
          if (divCnt == 14'h0000) begin
            actSrc      <= reqSrc;                         // [R19]
            actCode     <= reqCode;
            state       <= crc_pkg::CK_RUN;
            clkChanging <= 1'b0;                           // [R19]
          end
        end
        default: begin
          state       <= crc_pkg::CK_RUN;
          clkChanging <= 1'b0;
        end
      endcase
    end
  end

  // Registered read port; unmapped offsets read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfrRdata <= 8'h00;
    end else if (sfrRead) begin
      case (sfrAddr)
        `CRC_ADDR_SELDIV: sfrRdata <= core_clock_select_divide;
        `CRC_ADDR_WAKE:   sfrRdata <= {clkChanging, rc_wake_status, 6'h00}; // [R6] [R9]
        `CRC_ADDR_PWRCTL: sfrRdata <= {6'h00, power_down_request, 1'b0};
        `CRC_ADDR_GATE0:  sfrRdata <= periph_clock_gate_zero;
        `CRC_ADDR_GATE1:  sfrRdata <= periph_clock_gate_one;
        `CRC_ADDR_GATE2:  sfrRdata <= periph_clock_gate_two;
        `CRC_ADDR_GATE3:  sfrRdata <= periph_clock_gate_three;
        default:          sfrRdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_pd_entry;
    wrPwr && sfrWdata[`CRC_PD_BIT] && !power_down_request && !sysReset;
  endsequence

  sequence s_rc_wake_held;
    rc_wake_status && (reqSrc == crc_pkg::SRC_RC);
  endsequence

  a_pd_sets_wake: assert property (s_pd_entry |=> s_rc_wake_held) // [R7]
    else $error("power-down entry did not move the core to RC");
  a_rc_select: assert property (core_clock_select_divide[`CRC_RCSEL_BIT] |-> // [R3]
    reqSrc == crc_pkg::SRC_RC)
    else $error("RC select ignored");
  a_tap_select: assert property (!rc_wake_status && xtalOk && // [R4]
    !core_clock_select_divide[`CRC_RCSEL_BIT] |->
    reqSrc == (core_clock_select_divide[`CRC_X16SEL_BIT] ? crc_pkg::SRC_X16 : crc_pkg::SRC_X8))
    else $error("crystal tap selection wrong");
  a_xtal_wait: assert property (!xtalOk |-> reqSrc == crc_pkg::SRC_RC) // [R10]
    else $error("crystal used before stable");
  a_div_wrap: assert property (srcTick && divCnt == actLim |=> // [R1]
    coreClkTick && divCnt == 14'h0000)
    else $error("divider period wrong");
  a_change_flag: assert property (state == crc_pkg::CK_RUN && // [R6]
    (reqSrc != actSrc || reqCode != actCode) |=> clkChanging ##1 $stable(actSrc) || !clkChanging)
    else $error("clock change not flagged");
  a_wake_reserved: assert property (sfrRead && sfrAddr == `CRC_ADDR_WAKE |=> // [R9]
    sfrRdata[5:0] == 6'h00 && sfrRdata[`CRC_RCWAKE_BIT] == $past(rc_wake_status))
    else $error("wake status read wrong");
  a_pd_clear: assert property (wakeIrq && !wrPwr && power_down_request |=> // [R18]
    !power_down_request)
    else $error("wake did not clear power-down");
  a_ext_reset: assert property (extLow && extLowCnt == 16'(EXT_RST_CYCLES - 1) |=> // [R15]
    ##1 sysReset)
    else $error("long pin low did not reset");
  a_gate_restore: assert property (sysReset |=> periph_clock_gate_two == `CRC_GATE2_RST && // [R16]
    core_clock_select_divide == `CRC_SELDIV_RST)
    else $error("registers not restored by reset");

endmodule

// [verilog/crc_params.svh]
/*
  Constants for the core clock and reset controller: register offsets,
  field positions, reset values and timing figures.
  Assumes a 250 MHz reference clock and an 8-bit special function bus.
*/
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// Register offsets
`define CRC_ADDR_PWRCTL     8'h87
`define CRC_ADDR_SELDIV     8'h8E
`define CRC_ADDR_WAKE       8'h8F
`define CRC_ADDR_GATE3      8'h92
`define CRC_ADDR_GATE0      8'h98
`define CRC_ADDR_GATE1      8'h99
`define CRC_ADDR_GATE2      8'h9A

// Field positions
`define CRC_DIV8_HI         7
`define CRC_DIV8_LO         5
`define CRC_RCSEL_BIT       4
`define CRC_X16SEL_BIT      3
`define CRC_DIV16_HI        2
`define CRC_DIV16_LO        0
`define CRC_CHG_BIT         7
`define CRC_RCWAKE_BIT      6
`define CRC_PD_BIT          1
`define CRC_GATE3_MASK      8'h0F

// Reset values
`define CRC_SELDIV_RST      8'h00
`define CRC_GATE0_RST       8'h70
`define CRC_GATE1_RST       8'h00
`define CRC_GATE2_RST       8'h07
`define CRC_GATE3_RST       8'h01
`define CRC_PC_RESET        16'h0000
// Synchronisers start with power-on, brown-out and watchdog asserted, the reset pin high and the crystal not ready,
// so the system reset stays up until the real levels have been sampled twice
`define CRC_SYNC_RST        5'h1E

// Divider ratios minus one, codes 0 to 7
`define CRC_LIM0            14'h0000
`define CRC_LIM1            14'h0001
`define CRC_LIM2            14'h0003
`define CRC_LIM3            14'h0007
`define CRC_LIM4            14'h001F
`define CRC_LIM5            14'h01FF
`define CRC_LIM6            14'h0FFF
`define CRC_LIM7            14'h3FFF

// Timing
`define CRC_CLK_MHZ         250.0
`define CRC_EXT_RST_US      62.5

`endif

// [verilog/crc_pkg.sv]
/*
  Types shared by the core clock and reset controller.
  Assumes nothing beyond the constants header.
*/
package crc_pkg;
  typedef enum logic [1:0] {SRC_X8, SRC_X16, SRC_RC} crc_src_t;
  typedef enum {CK_RUN, CK_SWITCH} crc_state_t;
endpackage

// [tb/crc_clock_reset_test.sv]
/*
  Self-checking bench for the core clock and reset controller.
  Assumes ticks of period 4, 2 and 3 cycles stand in for the 8 MHz tap,
  16 MHz tap and RC oscillator, and a short external reset filter.
*/
`timescale 1ns/1ns
`include "crc_params.svh"
module crc_clock_reset_test;
  logic        ref_clk, arst_n, sfrWrite, sfrRead, xtal8Tick, xtal16Tick, rcTick;
  logic        xtalStable, wakeIrq, macPhySoftReset, coreClkTick, clkChanging;
  logic        power_down_request, sysReset, macPhyReset;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, g0, g1, g2, g3, v;
  logic [3:0]  rsrc;
  logic [15:0] resetVector;
  logic [31:0] seed;
  logic [7:0]  mdl [0:255];
  int          n_errors, n_compared, cyc, i, c;
  int          rat [8] = '{1, 2, 4, 8, 32, 512, 4096, 16384};
  logic [7:0]  adr [7] = '{8'h8E, 8'h8F, 8'h92, 8'h98, 8'h99, 8'h9A, 8'h80};

  // Short filter keeps the pin test brief
  crc_clock_reset #(.EXT_RST_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .xtal8Tick(xtal8Tick), .xtal16Tick(xtal16Tick), .rcTick(rcTick),
    .xtalStable(xtalStable), .external_reset_pin_n(~rsrc[0]), .powerOnReset(rsrc[1]),
    .brownout_reset(rsrc[2]), .watchdogTimeout(rsrc[3]), .wakeIrq(wakeIrq),
    .macPhySoftReset(macPhySoftReset), .coreClkTick(coreClkTick),
    .clkChanging(clkChanging), .power_down_request(power_down_request),
    .sysReset(sysReset), .macPhyReset(macPhyReset), .resetVector(resetVector),
    .periph_clock_gate_zero(g0), .periph_clock_gate_one(g1),
    .periph_clock_gate_two(g2), .periph_clock_gate_three(g3));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic logic sig(input int w);
    return (w == 0) ? clkChanging : (w == 1) ? coreClkTick : sysReset;
  endfunction

  function automatic logic [7:0] gport(input logic [7:0] a);
    return (a == 8'h98) ? g0 : (a == 8'h99) ? g1 : (a == 8'h9A) ? g2 : g3;
  endfunction

  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst_mdl;
    mdl = '{default: 8'h00};
    mdl[8'h92] = `CRC_GATE3_RST;
    mdl[8'h98] = `CRC_GATE0_RST;
    mdl[8'h9A] = `CRC_GATE2_RST;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr  <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge ref_clk);
    sfrWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge ref_clk);
    sfrRead <= 1'b0;
    @(posedge ref_clk);
    #1 chk(sfrRdata & m, exp);
  endtask

  // Bounded wait, sampled on the falling edge where outputs are settled
  task automatic wt(input int w, input logic val, input int bound);
    for (int t = 0; t < bound && sig(w) !== val; t++) @(negedge ref_clk);
    chk(sig(w), val);
  endtask

  // Skips the first two periods after a switch, then counts one whole period
  task automatic meas(input int exp);
    int n;
    repeat (4) @(negedge ref_clk);
    wt(0, 1'b0, 70000);
    wt(1, 1'b1, 70000);
    @(negedge ref_clk);
    wt(1, 1'b1, 70000);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (coreClkTick !== 1'b1 && n < 70000);
    chk(n, exp);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc        <= cyc + 1;
    xtal8Tick  <= (cyc % 4 == 0);
    xtal16Tick <= (cyc % 2 == 0);
    rcTick     <= (cyc % 3 == 0);
    if (cyc >= 90000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    {arst_n, sfrWrite, sfrRead, xtal8Tick, xtal16Tick, rcTick} = '0;
    {xtalStable, wakeIrq, macPhySoftReset, rsrc, sfrAddr, sfrWdata} = '0;
    n_errors = 0;
    n_compared = 0;
    cyc = 0;
    seed = 32'h0E7E4F59;
    rst_mdl();
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 7; i++) rd(adr[i], mdl[adr[i]], 8'hFF);
    chk(resetVector, `CRC_PC_RESET);
    meas(3);
    @(posedge ref_clk) xtalStable <= 1'b1;
    meas(4);
    for (c = 0; c < 6; c++) begin
      wr(8'h8E, 8'(c << 5));
      meas(4 * rat[c]);
    end
    // Let the old 2048-cycle period get under way, so the switch must wait
    repeat (8) @(posedge ref_clk);
    wr(8'h8E, 8'h00);
    @(posedge ref_clk);
    #1 chk(clkChanging, 1'b1);
    rd(8'h8F, 8'h80, 8'hFF);
    meas(4);
    for (c = 0; c < 7; c++) begin
      wr(8'h8E, 8'h08 | 8'(c));
      meas(2 * rat[c]);
    end
    wr(8'h8E, 8'hF9);
    meas(6);
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      v = adr[2 + i % 4];
      mdl[v] = (v == 8'h92) ? seed[7:0] & `CRC_GATE3_MASK : seed[7:0];
      wr(v, seed[7:0]);
      #1 chk(gport(v), mdl[v]);
      rd(v, mdl[v], 8'hFF);
    end
    wr(8'h8E, 8'h01);
    meas(4);
    wr(8'h87, 8'h02);
    #1 chk(power_down_request, 1'b1);
    rd(8'h87, 8'h02, 8'hFF);
    rd(8'h8F, 8'h40, 8'h7F);
    meas(6);
    wr(8'h8F, 8'hFF);
    rd(8'h8F, 8'h40, 8'h7F);
    @(posedge ref_clk) wakeIrq <= 1'b1;
    @(posedge ref_clk) wakeIrq <= 1'b0;
    #1 chk(power_down_request, 1'b0);
    meas(6);
    wr(8'h8F, 8'h00);
    meas(4);
    @(posedge ref_clk) macPhySoftReset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk({sysReset, macPhyReset}, 2'b01);
    macPhySoftReset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(macPhyReset, 1'b0);
    // Pin low for less than the filter length must be ignored
    @(posedge ref_clk) rsrc <= 4'h1;
    repeat (4) @(posedge ref_clk);
    rsrc <= 4'h0;
    v = 8'h00;
    repeat (20) @(negedge ref_clk) v = v | 8'(sysReset);
    chk(v, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(8'h99, 8'hA5);
      wr(8'h98, 8'h0F);
      @(posedge ref_clk) rsrc <= 4'(1 << i);
      wt(2, 1'b1, 40);
      chk(macPhyReset, 1'b1);
      @(posedge ref_clk) rsrc <= 4'h0;
      wt(2, 1'b0, 40);
      rd(8'h99, `CRC_GATE1_RST, 8'hFF);
      chk(g0, `CRC_GATE0_RST);
      chk(g3, `CRC_GATE3_RST);
      chk(resetVector, `CRC_PC_RESET);
    end
    stop_test();
  end
endmodule
